// File: core/modem_adc_test_regs.vh
// Register map, field positions, reset values and constants of the ADC and modem test registers
`ifndef MODEM_ADC_TEST_REGS_VH
`define MODEM_ADC_TEST_REGS_VH

// Register indices; the APB byte address is four times the index
`define IDX_ADC_TUNING_A        16'h61B5
`define IDX_ADC_TUNING_B        16'h61B6
`define IDX_ADC_EXPORT_CTRL     16'h61B7
`define IDX_TONE_DC_CTRL        16'h61B8
`define IDX_MODEM_AUX_CTRL      16'h61C0
`define IDX_MODEM_STATUS        16'h61C1
`define ADDR_OF(idx)            {idx, 2'b00}
`define APB_ADDR_W              18

// Reset values
`define RST_ADC_TUNING_A        8'h10
`define RST_ADC_TUNING_B        8'h0E
`define RST_ADC_EXPORT_CTRL     8'h03
`define RST_TONE_DC_CTRL        8'h75
`define RST_MODEM_AUX_CTRL      8'h00

// adc_tuning_a fields
`define F_REF_ADJ               7:6
`define F_QUANT_ADJ             5:4
`define F_GM_ADJ                3:1
`define F_AUX_DAC_EN            0
// adc_tuning_b fields
`define F_ANALOG_TEST_SEL       7:4
`define F_CAP_TWO               3:2
`define F_CAP_THREE             1:0
// adc_sample_export_ctrl fields
`define EXPORT_CTRL_WMASK       8'h7F
`define F_EXPORT_MODE           6:5
`define F_ANTIALIAS_SERIES_RES                4:3
`define F_FF_ADJ                2:1
`define F_ROTATION_EN           0
// tone_and_dc_removal_ctrl fields
`define F_TONE_STEP             7:4
`define F_DC_WIN                3:2
`define F_DC_MODE               1:0
// modem_aux_ctrl and modem_status fields
`define AUX_CTRL_WMASK          8'h01
`define F_TONE_ONLY             0
`define ST_DC_HOLD              0
`define ST_EXPORT_VALID         1
`define ST_EXPORT_FULL          2

// Sample export modes
`define EXPORT_OFF              2'b00
`define EXPORT_IQ               2'b01
`define EXPORT_I_PAIR           2'b10
`define EXPORT_Q_PAIR           2'b11

// dc blocker modes
`define DC_MODE_PASS            2'b00
`define DC_MODE_TRACK           2'b01
`define DC_MODE_FREEZE          2'b10

// dc window: 32 << code samples, log2 of 32 is the base shift
`define DC_WIN_BASE_LOG2        5
`define DC_WIN_BASE             9'h020

// Tone generator: offsets in kHz, tone sample rate equal to clk (20 MHz)
`define TONE_FS_KHZ             20000
`define TONE_PHASE_SCALE        65536
`define TONE_QUARTER            16'h4000
// 16-entry signed sine table, entry 0 in the low byte
`define SINE_TABLE              128'hCFA68B818BA6CF00_315A757F755A3100
`define SINE_IDX_HI             15
`define SINE_IDX_LO             12

`endif

// File: core/two_entry_buffer.v
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/10ps
`include "modem_adc_test_regs.vh"

module two_entry_buffer (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire        flush,
    input  wire        in_valid,
    input  wire [15:0] in_data,
    output wire        in_ready,
    output wire        out_valid,
    output wire [15:0] out_data,
    input  wire        out_ready
);
    reg        head_valid_reg;
    reg [15:0] head_data_reg;
    reg        tail_valid_reg;
    reg [15:0] tail_data_reg;
    reg        tail_free_reg;
    wire       push;
    wire       pop;

    assign in_ready  = tail_free_reg;
    assign out_valid = head_valid_reg;
    assign out_data  = head_data_reg;
    assign push      = in_valid & ~tail_valid_reg;
    assign pop       = head_valid_reg & out_ready;

    always @(posedge clk) begin
        if (rst) begin
            head_valid_reg <= 1'b0;
            head_data_reg  <= 16'h0000;
            tail_valid_reg <= 1'b0;
            tail_data_reg  <= 16'h0000;
            tail_free_reg  <= 1'b1;
        end else if (ce) begin
            if (flush) begin
                head_valid_reg <= 1'b0;
                tail_valid_reg <= 1'b0;
                tail_free_reg  <= 1'b1;
            end else if (pop) begin
                // Tail moves up first; push cannot coincide while tail is held
                if (tail_valid_reg) begin
                    head_data_reg  <= tail_data_reg;
                    tail_valid_reg <= 1'b0;
                    tail_free_reg  <= 1'b1;
                end else if (push) begin
                    head_data_reg <= in_data;
                end else begin
                    head_valid_reg <= 1'b0;
                end
            end else if (push) begin
                if (!head_valid_reg) begin
                    head_data_reg  <= in_data;
                    head_valid_reg <= 1'b1;
                end else begin
                    tail_data_reg  <= in_data;
                    tail_valid_reg <= 1'b1;
                    tail_free_reg  <= 1'b0;
                end
            end
        end
    end
endmodule

// File: core/dc_blocker.v
// Accumulate-and-dump dc estimator and subtractor for one converter branch
`timescale 1ns/10ps
`include "modem_adc_test_regs.vh"

module dc_blocker (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       in_valid,
    input  wire [7:0] in_data,
    input  wire [1:0] win_code,
    input  wire [1:0] mode,
    input  wire       frame_sync,
    output reg  [8:0] out_data,
    output reg        out_valid,
    output wire       hold_active
);
    reg  [16:0] acc_reg;
    reg  [7:0]  count_reg;
    reg  [7:0]  est_reg;
    wire [16:0] acc_next;
    wire [8:0]  win_len;
    wire [16:0] dump_val;
    wire        dump;

    assign acc_next    = acc_reg + {{9{in_data[7]}}, in_data};
    assign win_len     = `DC_WIN_BASE << win_code;
    assign dump        = ({1'b0, count_reg} == win_len - 9'h001);
    assign dump_val    = $signed(acc_next) >>> (`DC_WIN_BASE_LOG2 + win_code);
    // Estimate is held while a frame is locked in freeze mode
    assign hold_active = (mode == `DC_MODE_FREEZE) & frame_sync;

    always @(posedge clk) begin
        if (rst) begin
            acc_reg   <= 17'h00000;
            count_reg <= 8'h00;
            est_reg   <= 8'h00;
            out_data  <= 9'h000;
            out_valid <= 1'b0;
        end else if (ce) begin
            out_valid <= in_valid;
            if (in_valid) begin
                if (dump) begin
                    acc_reg   <= 17'h00000;
                    count_reg <= 8'h00;
                    if (!hold_active)
                        est_reg <= dump_val[7:0];
                end else begin
                    acc_reg   <= acc_next;
                    count_reg <= count_reg + 8'h01;
                end
                if (mode == `DC_MODE_TRACK || mode == `DC_MODE_FREEZE)
                    out_data <= {in_data[7], in_data} - {est_reg[7], est_reg};
                else
                    out_data <= {in_data[7], in_data};
            end
        end
    end
endmodule

// File: core/modem_adc_test_registers.v
// ADC and modem test register bank with sample export, test tone and dc removal
`timescale 1ns/10ps
`include "modem_adc_test_regs.vh"

module modem_adc_test_registers (
    input  wire                   clk,
    input  wire                   rst,
    input  wire                   ce,
    // APB slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`APB_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    // Converter samples from the demodulator input
    input  wire                   adc_valid,
    input  wire [7:0]             adc_i,
    input  wire [7:0]             adc_q,
    output wire                   adc_ready,
    input  wire                   frame_sync,
    // dc-removed samples
    output wire                   dc_valid,
    output wire [8:0]             dc_i,
    output wire [8:0]             dc_q,
    // Sample export on general-purpose pins
    output wire                   gpio_valid,
    output wire [15:0]            gpio_data,
    input  wire                   gpio_ready,
    // Transmit path
    input  wire [7:0]             mod_i,
    input  wire [7:0]             mod_q,
    output reg  [8:0]             tx_i,
    output reg  [8:0]             tx_q,
    // Analog controls
    output wire [1:0]             reference_threshold_adjust,
    output wire [1:0]             quantizer_threshold_adjust,
    output wire [2:0]             transconductance_adjust,
    output wire                   aux_feedback_converter_en,
    output wire [3:0]             analog_test_select,
    output wire [1:0]             cap_two_adjust,
    output wire [1:0]             cap_three_adjust,
    output wire [1:0]             antialias_series_res,
    output wire [1:0]             feedforward_adjust,
    output wire                   element_rotation_en
);
    reg  [7:0]  adc_tuning_a_reg;
    reg  [7:0]  adc_tuning_b_reg;
    reg  [7:0]  adc_sample_export_ctrl_reg;
    reg  [7:0]  tone_and_dc_removal_ctrl_reg;
    reg  [7:0]  modem_aux_ctrl_reg;
    reg         gpio_ready_meta_reg;
    reg         gpio_ready_sync_reg;
    reg         pair_have_reg;
    reg  [7:0]  pair_data_reg;
    reg  [15:0] phase_reg;
    reg  [7:0]  read_next;
    reg         hit_next;
    reg         push_next;
    reg  [15:0] push_data_next;
    wire [1:0]  export_mode;
    wire        export_off;
    wire        sample_taken;
    wire        apb_setup;
    wire        apb_write;
    wire        buf_full;
    wire        dc_hold_i;
    wire        dc_hold_q;
    wire        dc_valid_q;
    wire [7:0]  tone_sin;
    wire [7:0]  tone_cos;
    wire        tone_only_select;
    wire [7:0]  status_word;

    // Sine lookup of the upper phase bits
    function [7:0] sine_lookup;
        input [15:0] phase;
        reg   [127:0] table_bits;
        begin
            table_bits  = `SINE_TABLE;
            sine_lookup = table_bits[{phase[`SINE_IDX_HI:`SINE_IDX_LO], 3'b000} +: 8];
        end
    endfunction

    // Phase increment for a frequency offset in kHz at the tone sample rate
    function [15:0] khz_to_step;
        input integer khz;
        integer       inc;
        begin
            inc         = (khz * `TONE_PHASE_SCALE) / `TONE_FS_KHZ;
            khz_to_step = inc[15:0];
        end
    endfunction

    // Step code to phase increment; undefined codes give no rotation
    function [15:0] tone_step;
        input [3:0] code;
        begin
            case (code)
                4'h0: tone_step = khz_to_step(-6000);
                4'h1: tone_step = khz_to_step(-4000);
                4'h2: tone_step = khz_to_step(-3000);
                4'h3: tone_step = khz_to_step(-2000);
                4'h4: tone_step = khz_to_step(-1000);
                4'h5: tone_step = khz_to_step(-500);
                4'h7: tone_step = khz_to_step(0);
                4'h8: tone_step = khz_to_step(500);
                4'h9: tone_step = khz_to_step(1000);
                4'hA: tone_step = khz_to_step(2000);
                4'hB: tone_step = khz_to_step(3000);
                4'hC: tone_step = khz_to_step(4000);
                4'hD: tone_step = khz_to_step(6000);
                default: tone_step = 16'h0000;
            endcase
        end
    endfunction

    // Sign extension of an 8-bit sample to 9 bits
    function [8:0] sext9;
        input [7:0] v;
        begin
            sext9 = {v[7], v};
        end
    endfunction

    // Analog controls straight from stored fields
    assign reference_threshold_adjust = adc_tuning_a_reg[`F_REF_ADJ];
    assign quantizer_threshold_adjust = adc_tuning_a_reg[`F_QUANT_ADJ];
    assign transconductance_adjust    = adc_tuning_a_reg[`F_GM_ADJ];
    assign aux_feedback_converter_en  = adc_tuning_a_reg[`F_AUX_DAC_EN];
    assign analog_test_select         = adc_tuning_b_reg[`F_ANALOG_TEST_SEL];
    assign cap_two_adjust             = adc_tuning_b_reg[`F_CAP_TWO];
    assign cap_three_adjust           = adc_tuning_b_reg[`F_CAP_THREE];
    assign antialias_series_res       = adc_sample_export_ctrl_reg[`F_ANTIALIAS_SERIES_RES];
    assign feedforward_adjust         = adc_sample_export_ctrl_reg[`F_FF_ADJ];
    assign element_rotation_en        = adc_sample_export_ctrl_reg[`F_ROTATION_EN];
    assign tone_only_select           = modem_aux_ctrl_reg[`F_TONE_ONLY];

    assign export_mode  = adc_sample_export_ctrl_reg[`F_EXPORT_MODE];
    assign export_off   = (export_mode == `EXPORT_OFF);
    assign sample_taken = adc_valid & adc_ready;
    assign apb_setup    = psel & ~penable & ~pready;
    assign apb_write    = psel & penable & pready & pwrite & ~pslverr;
    assign status_word  = {5'b00000, buf_full, gpio_valid, dc_hold_i};
    assign buf_full     = ~adc_ready;

    // APB read mux and address decode
    always @* begin
        read_next = 8'h00;
        hit_next  = 1'b1;
        case (paddr)
            `ADDR_OF(`IDX_ADC_TUNING_A):    read_next = adc_tuning_a_reg;
            `ADDR_OF(`IDX_ADC_TUNING_B):    read_next = adc_tuning_b_reg;
            `ADDR_OF(`IDX_ADC_EXPORT_CTRL): read_next = adc_sample_export_ctrl_reg & `EXPORT_CTRL_WMASK;
            `ADDR_OF(`IDX_TONE_DC_CTRL):    read_next = tone_and_dc_removal_ctrl_reg;
            `ADDR_OF(`IDX_MODEM_AUX_CTRL):  read_next = modem_aux_ctrl_reg & `AUX_CTRL_WMASK;
            `ADDR_OF(`IDX_MODEM_STATUS):    read_next = status_word;
            default:                        hit_next  = 1'b0;
        endcase
    end

    // APB slave: one access cycle, no wait states
    always @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (apb_setup) begin
                pready  <= 1'b1;
                pslverr <= ~hit_next;
                prdata  <= {24'h000000, read_next};
            end
        end
    end

    // Register writes take effect at the completing access edge
    always @(posedge clk) begin
        if (rst) begin
            adc_tuning_a_reg             <= `RST_ADC_TUNING_A;
            adc_tuning_b_reg             <= `RST_ADC_TUNING_B;
            adc_sample_export_ctrl_reg   <= `RST_ADC_EXPORT_CTRL;
            tone_and_dc_removal_ctrl_reg <= `RST_TONE_DC_CTRL;
            modem_aux_ctrl_reg           <= `RST_MODEM_AUX_CTRL;
        end else if (ce && apb_write) begin
            case (paddr)
                `ADDR_OF(`IDX_ADC_TUNING_A):    adc_tuning_a_reg <= pwdata[7:0];
                `ADDR_OF(`IDX_ADC_TUNING_B):    adc_tuning_b_reg <= pwdata[7:0];
                `ADDR_OF(`IDX_ADC_EXPORT_CTRL): adc_sample_export_ctrl_reg <= pwdata[7:0] & `EXPORT_CTRL_WMASK;
                `ADDR_OF(`IDX_TONE_DC_CTRL):    tone_and_dc_removal_ctrl_reg <= pwdata[7:0];
                `ADDR_OF(`IDX_MODEM_AUX_CTRL):  modem_aux_ctrl_reg <= pwdata[7:0] & `AUX_CTRL_WMASK;
                default: ;
            endcase
        end
    end

    // Pin-side ready passes two flip-flops before use
    always @(posedge clk) begin
        if (rst) begin
            gpio_ready_meta_reg <= 1'b0;
            gpio_ready_sync_reg <= 1'b0;
        end else if (ce) begin
            gpio_ready_meta_reg <= gpio_ready;
            gpio_ready_sync_reg <= gpio_ready_meta_reg;
        end
    end

    // Sample export word assembly from raw converter samples
    always @* begin
        push_next      = 1'b0;
        push_data_next = {adc_i, adc_q};
        case (export_mode)
            `EXPORT_IQ: begin
                push_next      = sample_taken;
                push_data_next = {adc_i, adc_q};
            end
            `EXPORT_I_PAIR: begin
                push_next      = sample_taken & pair_have_reg;
                push_data_next = {pair_data_reg, adc_i};
            end
            `EXPORT_Q_PAIR: begin
                push_next      = sample_taken & pair_have_reg;
                push_data_next = {pair_data_reg, adc_q};
            end
            default: push_next = 1'b0;
        endcase
    end

    // First sample of a pair waits here for its partner
    always @(posedge clk) begin
        if (rst) begin
            pair_have_reg <= 1'b0;
            pair_data_reg <= 8'h00;
        end else if (ce) begin
            if (export_off || export_mode == `EXPORT_IQ) begin
                pair_have_reg <= 1'b0;
            end else if (sample_taken) begin
                pair_have_reg <= ~pair_have_reg;
                pair_data_reg <= (export_mode == `EXPORT_I_PAIR) ? adc_i : adc_q;
            end
        end
    end

    two_entry_buffer export_buf (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .flush     (export_off),
        .in_valid  (push_next),
        .in_data   (push_data_next),
        .in_ready  (adc_ready),
        .out_valid (gpio_valid),
        .out_data  (gpio_data),
        .out_ready (gpio_ready_sync_reg)
    );

    dc_blocker dc_blk_i (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .in_valid    (sample_taken),
        .in_data     (adc_i),
        .win_code    (tone_and_dc_removal_ctrl_reg[`F_DC_WIN]),
        .mode        (tone_and_dc_removal_ctrl_reg[`F_DC_MODE]),
        .frame_sync  (frame_sync),
        .out_data    (dc_i),
        .out_valid   (dc_valid),
        .hold_active (dc_hold_i)
    );

    dc_blocker dc_blk_q (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .in_valid    (sample_taken),
        .in_data     (adc_q),
        .win_code    (tone_and_dc_removal_ctrl_reg[`F_DC_WIN]),
        .mode        (tone_and_dc_removal_ctrl_reg[`F_DC_MODE]),
        .frame_sync  (frame_sync),
        .out_data    (dc_q),
        .out_valid   (dc_valid_q),
        .hold_active (dc_hold_q)
    );

    // Test tone: phase accumulator feeding sine and cosine lookups
    assign tone_sin = sine_lookup(phase_reg);
    assign tone_cos = sine_lookup(phase_reg + `TONE_QUARTER);

    always @(posedge clk) begin
        if (rst) begin
            phase_reg <= 16'h0000;
            tx_i      <= 9'h000;
            tx_q      <= 9'h000;
        end else if (ce) begin
            phase_reg <= phase_reg + tone_step(tone_and_dc_removal_ctrl_reg[`F_TONE_STEP]);
            if (tone_only_select) begin
                tx_i <= sext9(tone_cos);
                tx_q <= sext9(tone_sin);
            end else begin
                tx_i <= sext9(mod_i) + sext9(tone_cos);
                tx_q <= sext9(mod_q) + sext9(tone_sin);
            end
        end
    end
endmodule

// File: dv/modem_adc_test_chk.sv
// Concurrent assertions on the ports of the test register bank
`timescale 1ns/10ps
module modem_adc_test_chk (
    input wire        clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        adc_valid,
    input wire        adc_ready,
    input wire        dc_valid,
    input wire        gpio_valid,
    input wire [15:0] gpio_data,
    input wire        gpio_ready,
    input wire [2:0]  transconductance_adjust,
    input wire        element_rotation_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_rot_reset: assert property ($fell(rst) |-> element_rotation_en)
        else $error("rotation enable not set after reset");
    chk_ack_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup cycle");
    chk_ack_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_read_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    chk_err_ack: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("error response malformed");
    chk_dc_follow: assert property (adc_valid && adc_ready |=> dc_valid)
        else $error("no dc output after taken sample");
    chk_dc_cause: assert property (dc_valid |-> $past(adc_valid && adc_ready))
        else $error("dc output without sample");
    chk_word_cause: assert property ($rose(gpio_valid) |-> $past(adc_valid && adc_ready))
        else $error("export word without sample");
    chk_word_hold: assert property (!gpio_ready ##1 !gpio_ready ##1 (gpio_valid && !gpio_ready) |=>
        gpio_valid && $stable(gpio_data))
        else $error("export word lost while stalled");
    chk_tune_write: assert property (!$stable(transconductance_adjust) |-> $past(psel && penable && pwrite))
        else $error("tuning output changed without write");
    cover property (pslverr);
    cover property (gpio_valid && !adc_ready);
    cover property (dc_valid);
endmodule
bind modem_adc_test_registers modem_adc_test_chk chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .dc_valid(dc_valid), .gpio_valid(gpio_valid), .gpio_data(gpio_data),
    .gpio_ready(gpio_ready), .transconductance_adjust(transconductance_adjust),
    .element_rotation_en(element_rotation_en));

// File: dv/gpio_sink.sv
// Test equipment model that accepts exported words on the pins
`timescale 1ns/10ps
module gpio_sink (
    input  wire clk,
    input  wire pop,
    output reg  gpio_ready
);
    initial gpio_ready = 1'b0;
    // Ready only pulses on request, so the bank must hold words while stalled
    always @(posedge clk) begin
        gpio_ready <= pop;
    end
endmodule

// File: dv/modem_adc_test_registers_test.sv
// Self-checking bench for the ADC and modem test register bank
`timescale 1ns/10ps
`include "modem_adc_test_regs.vh"
module modem_adc_test_registers_test;
    reg         clk, rst, psel, penable, pwrite, adc_valid, frame_sync, pop, er;
    reg  [17:0] paddr;
    reg  [31:0] pwdata, rd;
    reg  [7:0]  adc_i, adc_q, mod_i;
    reg  [8:0]  t0;
    wire [31:0] prdata;
    wire        pready, pslverr, adc_ready, dc_valid, gpio_valid, gpio_ready;
    wire [15:0] gpio_data;
    wire [8:0]  dc_i, tx_i;
    wire [7:0]  ta, tv;
    wire [4:0]  ec;
    integer     err_count, comparisons, n;
    modem_adc_test_registers uut (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_valid(adc_valid), .adc_i(adc_i), .adc_q(adc_q), .adc_ready(adc_ready), .frame_sync(frame_sync),
        .dc_valid(dc_valid), .dc_i(dc_i), .dc_q(), .gpio_valid(gpio_valid), .gpio_data(gpio_data),
        .gpio_ready(gpio_ready), .mod_i(mod_i), .mod_q(8'h00), .tx_i(tx_i), .tx_q(),
        .reference_threshold_adjust(ta[7:6]), .quantizer_threshold_adjust(ta[5:4]),
        .transconductance_adjust(ta[3:1]), .aux_feedback_converter_en(ta[0]), .analog_test_select(tv[7:4]),
        .cap_two_adjust(tv[3:2]), .cap_three_adjust(tv[1:0]), .antialias_series_res(ec[4:3]),
        .feedforward_adjust(ec[2:1]), .element_rotation_en(ec[0]));
    gpio_sink sink (.clk(clk), .pop(pop), .gpio_ready(gpio_ready));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [15:0] idx, input [7:0] wd);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {idx, 2'b00};
            pwdata <= {24'h000000, wd};
            @(posedge clk);
            penable <= 1'b1;
            do @(posedge clk); while (!pready);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rdc(input [15:0] idx, input [7:0] exp);
        begin
            bus(1'b0, idx, 8'h00);
            chk(rd, {24'h000000, exp});
        end
    endtask
    task smp(input [7:0] i, input [7:0] q);
        begin
            adc_i <= i;
            adc_q <= q;
            adc_valid <= 1'b1;
            do @(posedge clk); while (!adc_ready);
            adc_valid <= 1'b0;
            @(posedge clk);
        end
    endtask
    task popw;
        begin
            pop <= 1'b1;
            @(posedge clk);
            pop <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count = err_count + 1;
        tally_and_finish;
    end
    initial begin
        {rst, psel, penable, pwrite, adc_valid, frame_sync, pop} = 7'h40;
        {paddr, pwdata, adc_i, adc_q, mod_i} = 0;
        err_count = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(16'h61B5, 8'h10);
        rdc(16'h61B6, 8'h0E);
        rdc(16'h61B7, 8'h03);
        rdc(16'h61B8, 8'h75);
        chk({8'h00, ta, tv, 3'b000, ec}, 32'h00100E03);
        $display("test reset values done");
        for (n = 0; n < 4; n = n + 1) begin
            bus(1'b1, 16'h61B5 + n[15:0], 8'hFF);
            rdc(16'h61B5 + n[15:0], n == 2 ? 8'h7F : 8'hFF);
        end
        chk({8'h00, ta, tv, 3'b000, ec}, 32'h00FFFF1F);
        bus(1'b1, 16'h61B7, 8'h02);
        chk({27'h0, ec}, 32'h02);
        bus(1'b0, 16'h61B9, 8'h00);
        chk({er, rd[30:0]}, 32'h80000000);
        $display("test register access done");
        bus(1'b1, 16'h61B8, 8'h70);
        bus(1'b1, 16'h61B7, 8'h23);
        smp(8'h12, 8'h34);
        smp(8'h56, 8'h78);
        chk({15'h0, adc_ready, gpio_data}, 32'h1234);
        popw;
        chk({16'h0, gpio_data}, 32'h5678);
        popw;
        for (n = 0; n < 2; n = n + 1) begin
            bus(1'b1, 16'h61B7, n == 0 ? 8'h43 : 8'h63);
            smp(8'hA1, 8'hB1);
            smp(8'hA2, 8'hB2);
            chk({16'h0, gpio_data}, n == 0 ? 32'hA1A2 : 32'hB1B2);
            popw;
        end
        bus(1'b1, 16'h61B7, 8'h03);
        smp(8'h9A, 8'h9B);
        chk({31'h0, gpio_valid}, 32'h0);
        $display("test sample export done");
        smp(8'hF6, 8'h00);
        chk({23'h0, dc_i}, 32'h1F6);
        bus(1'b1, 16'h61B8, 8'h71);
        repeat (70) smp(8'h0A, 8'h0A);
        chk({23'h0, dc_i}, 32'h0);
        bus(1'b1, 16'h61B8, 8'h72);
        frame_sync <= 1'b1;
        repeat (70) smp(8'h14, 8'h14);
        chk({23'h0, dc_i}, 32'h00A);
        frame_sync <= 1'b0;
        repeat (70) smp(8'h14, 8'h14);
        chk({23'h0, dc_i}, 32'h0);
        $display("test dc removal done");
        bus(1'b1, 16'h61B8, 8'h70);
        repeat (3) @(posedge clk);
        t0 = tx_i;
        mod_i <= 8'h05;
        repeat (3) @(posedge clk);
        chk({23'h0, tx_i}, {23'h0, t0 + 9'h005});
        bus(1'b1, 16'h61C0, 8'h01);
        repeat (2) @(posedge clk);
        chk({23'h0, tx_i}, {23'h0, t0});
        bus(1'b1, 16'h61B8, 8'h00);
        repeat (2) @(posedge clk);
        t0 = tx_i;
        @(posedge clk);
        chk({31'h0, tx_i !== t0}, 32'h1);
        $display("test tone done");
        tally_and_finish;
    end
endmodule
